// ---- adv_timer_control_regs.sv ----
// Function
// - In debug halt the counter runs or freezes per the freeze bit.
// - Clock-divide field gives sample period of one, two or four clocks.
// - Reload value applies directly, or at update when buffering is on.
// - Alignment selects edge or center counting and when compare flags fire.
// - Direction bit selects down; read-only hardware direction in center/encoder.
// - Single-pulse mode clears the counter enable at the next update, unless a trigger start comes in that same cycle.
// - Update-source bit limits update requests to overflow or underflow.
// - Update enabled: wrap, software or slave update loads buffered values.
// - Update disabled: shadows kept, but counter still reinitialised.
// - Software enables counting; trigger mode sets the enable in hardware.
// - Complementary idle bits set comp level after dead-time, outputs off.
// - Main idle bits set main level when outputs off; channels one to three after dead-time, four at once.
// - Idle-level writes ignored while any lock level is programmed.
// - Combine bit makes channel input one the XOR of three pins.
// - Source 000 outputs software update; slave reset appears one cycle late.
// - Source 001 outputs internal enable; the gate part is one cycle late whatever the delay mode.
// - Source 010 outputs update; 011 pulses on each channel-one event.
// - Sources 100 to 111 output compare references of channels one to four.
// - Channel DMA requests follow own event, or update when selected.
// - Preloaded channel controls load at commutation; trigger edge optional.
// - Delay mode retimes trigger effects to align with slave timers.
`timescale 1ns/1ps
`default_nettype none
module adv_timer_control_regs
   import adv_timer_pkg::*;
#(
   parameter int DEAD_TICKS = DEAD_TICKS_DEF,
   parameter int CTRL_W     = 12
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [3:0]        reg_be,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   input  wire logic              debug_halt,
   input  wire logic              debug_freeze_bit,
   input  wire logic              trigger_input,
   input  wire logic [2:0]        chan_pin,
   input  wire logic              counter_wrap,
   input  wire logic              update_generate_request,
   input  wire logic              slave_update,
   input  wire logic              slave_trigger_start,
   input  wire logic              gated_active,
   input  wire logic              encoder_mode,
   input  wire logic              hw_dir_down,
   input  wire logic              master_slave_delay,
   input  wire logic [1:0]        lock_level,
   input  wire logic              main_output_enable,
   input  wire logic [3:0]        chan_main_wave,
   input  wire logic [2:0]        chan_comp_wave,
   input  wire logic [3:0]        channel_event,
   input  wire logic [3:0]        compare_reference,
   input  wire logic              commutation_generate,
   input  wire logic              arr_wr,
   input  wire logic [15:0]       arr_wdata,
   input  wire logic              cc_ctrl_wr,
   input  wire logic [CTRL_W-1:0] cc_ctrl_wdata,
   output logic                   count_run,
   output logic                   count_down,
   output logic                   compare_flag_enable,
   output logic                   dts_tick,
   output logic                   update_event,
   output logic                   update_irq_req,
   output logic                   counter_reinit,
   output logic                   channel_in_one,
   output logic      [3:0]        channel_dma_req,
   output logic                   commutation_event,
   output logic      [15:0]       auto_reload_value,
   output logic      [CTRL_W-1:0] cc_ctrl_active,
   output logic      [3:0]        main_out_pin,
   output logic      [2:0]        comp_out_pin,
   output logic                   trigger_output
);
   logic [15:0] ctrl_one_q, ctrl_two_q;
   logic [15:0] ctrl_one_d, ctrl_two_d;
   logic [5:0]  pins_s;
   logic        halt_s, freeze_s, trig_s;
   logic [2:0]  chan_s;
   logic        trig_d1_q, trig_rise, trig_eff, trig_rise_d1_q;
   logic        gate_d1_q, slave_upd_d1_q;
   logic [15:0] arr_pre_q;
   out_state_e  ost_q, ost_d;
   logic [7:0]  dead_cnt_q;

   pin_sync #(.W(6)) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({debug_halt, debug_freeze_bit, trigger_input, chan_pin}),
      .sync_out (pins_s)
   );
   assign {halt_s, freeze_s, trig_s, chan_s} = pins_s;

   // Sample clock divider
   // sample period
   dts_divider u_dts (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .divide_code (ctrl_one_q[CKD_LSB+:2]),
      .dts_tick    (dts_tick)
   );

   // Field decode
   wire       buf_en    = ctrl_one_q[RELOAD_BUFFER_ENABLE_BIT];
   wire [1:0] align     = ctrl_one_q[CMS_LSB+:2];
   wire       single_pulse_mode       = ctrl_one_q[OPM_BIT];
   wire       update_source_select       = ctrl_one_q[URS_BIT];
   wire       update_disable      = ctrl_one_q[UPDATE_DISABLE_BIT];
   wire       counter_enable_bit       = ctrl_one_q[CEN_BIT];
   wire [6:0] idle_lvl  = ctrl_two_q[OIS_MSB:OIS_LSB];
   wire       combine   = ctrl_two_q[INPUT_COMBINE_SELECT_BIT];
   wire [2:0] trigger_output_src  = ctrl_two_q[MMS_LSB+:3];
   wire       dma_sel   = ctrl_two_q[CHANNEL_DMA_SELECT_BIT];
   wire       comm_sel  = ctrl_two_q[COMMUTATION_SOURCE_SELECT_BIT];
   wire       ctrl_pre  = ctrl_two_q[CONTROL_PRELOAD_ENABLE_BIT];
   wire       hw_dir    = (align != ALIGN_EDGE) || encoder_mode;
   wire       wr_ok     = reg_wr && (reg_be == BE_HALF || reg_be == BE_WORD);
   wire       wr_one    = wr_ok && reg_addr == CTRL_ONE_OFF;
   wire       wr_two    = wr_ok && reg_addr == CTRL_TWO_OFF;
   wire       locked    = lock_level != LOCK_OFF;

   // Trigger edge, retimed by one cycle in delay mode
   // trigger retiming
   assign trig_rise = trig_s && !trig_d1_q;
   assign trig_eff  = master_slave_delay ? trig_rise_d1_q : trig_rise;

   // Update generation
   wire upd_any = counter_wrap || update_generate_request || slave_update;
   assign update_event   = !update_disable && upd_any;
   assign update_irq_req = update_event && (!update_source_select || counter_wrap);
   assign counter_reinit = update_generate_request || slave_update;

   wire gate_eff = master_slave_delay ? gate_d1_q : gated_active;
   wire int_en   = counter_enable_bit || gate_eff;
   assign count_run = int_en && !(halt_s && freeze_s);

   assign count_down = hw_dir ? hw_dir_down : ctrl_one_q[DIR_BIT];

   assign compare_flag_enable = (align == ALIGN_EDGE) || (align == ALIGN_BOTH) ||
                                (align == ALIGN_DOWN && count_down) ||
                                (align == ALIGN_UP && !count_down);

   assign channel_in_one = combine ? ^chan_s : chan_s[0];

   assign channel_dma_req = dma_sel ? {4{update_event}} : channel_event;

   assign commutation_event = commutation_generate || (comm_sel && trig_eff);

   // Register next values
   always_comb begin
      ctrl_one_d = ctrl_one_q;
      ctrl_two_d = ctrl_two_q;
      if (wr_one) begin
         ctrl_one_d = reg_wdata[15:0] & CTRL_ONE_MASK;
         if (hw_dir)
            ctrl_one_d[DIR_BIT] = ctrl_one_q[DIR_BIT];
      end
      if (single_pulse_mode && update_event)
         ctrl_one_d[CEN_BIT] = 1'b0;
      if (slave_trigger_start)
         ctrl_one_d[CEN_BIT] = 1'b1;
      if (wr_two) begin
         ctrl_two_d = reg_wdata[15:0] & CTRL_TWO_MASK;
         if (locked)
            ctrl_two_d[OIS_MSB:OIS_LSB] = idle_lvl;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_one_q <= CTRL_ONE_RST;
         ctrl_two_q <= CTRL_TWO_RST;
      end else begin
         ctrl_one_q <= ctrl_one_d;
         ctrl_two_q <= ctrl_two_d;
      end
   end

   // Read data holds the live direction; byte lanes are picked by the master
   wire [15:0] rd_one = {ctrl_one_q[15:DIR_BIT+1], count_down, ctrl_one_q[DIR_BIT-1:0]};
   wire [15:0] rd_sel = (reg_addr == CTRL_ONE_OFF) ? rd_one :
                        (reg_addr == CTRL_TWO_OFF) ? ctrl_two_q : 16'h0000;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= {16'h0000, rd_sel};
   end

   // Delay stages for trigger and slave events
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trig_d1_q      <= 1'b0;
         trig_rise_d1_q <= 1'b0;
         gate_d1_q      <= 1'b0;
         slave_upd_d1_q <= 1'b0;
      end else begin
         trig_d1_q      <= trig_s;
         trig_rise_d1_q <= trig_rise;
         gate_d1_q      <= gated_active;
         slave_upd_d1_q <= slave_update;
      end
   end

   // Reload value; the preload copy is what software writes
   // reload buffering
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         arr_pre_q         <= 16'h0000;
         auto_reload_value <= 16'h0000;
      end else begin
         if (arr_wr)
            arr_pre_q <= arr_wdata;
         if (arr_wr && !buf_en)
            auto_reload_value <= arr_wdata;
         else if (buf_en && update_event)
            auto_reload_value <= arr_wr ? arr_wdata : arr_pre_q;
      end
   end

   // Channel control preload
   logic [CTRL_W-1:0] cc_pre_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cc_pre_q       <= '0;
         cc_ctrl_active <= '0;
      end else begin
         if (cc_ctrl_wr)
            cc_pre_q <= cc_ctrl_wdata;
         if (cc_ctrl_wr && !ctrl_pre)
            cc_ctrl_active <= cc_ctrl_wdata;
         else if (ctrl_pre && commutation_event)
            cc_ctrl_active <= cc_ctrl_wr ? cc_ctrl_wdata : cc_pre_q;
      end
   end

   // Trigger output source
   logic trigger_output_d;
   always_comb begin
      case (trigger_output_src)
         TRIGGER_OUTPUT_RESET:  trigger_output_d = update_generate_request || slave_upd_d1_q;
         TRIGGER_OUTPUT_ENABLE: trigger_output_d = counter_enable_bit || gate_d1_q;
         TRIGGER_OUTPUT_UPDATE: trigger_output_d = update_event;
         TRIGGER_OUTPUT_PULSE:  trigger_output_d = channel_event[0];
         default:     trigger_output_d = compare_reference[trigger_output_src[1:0]];
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         trigger_output <= 1'b0;
      else
         trigger_output <= trigger_output_d;
   end

   // Output idle sequencing: both legs go inactive for the dead-time first,
   // so a pair never drives its idle levels through a shoot-through window
   always_comb begin
      case (ost_q)
         OUT_ACTIVE: ost_d = main_output_enable ? OUT_ACTIVE :
                             (DEAD_TICKS == 0) ? OUT_IDLE : OUT_DEAD;
         OUT_DEAD:   ost_d = main_output_enable ? OUT_ACTIVE :
                             (dts_tick && dead_cnt_q == 8'h01) ? OUT_IDLE : OUT_DEAD;
         OUT_IDLE:   ost_d = main_output_enable ? OUT_ACTIVE : OUT_IDLE;
         default:    ost_d = OUT_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ost_q      <= OUT_IDLE;
         dead_cnt_q <= 8'h00;
      end else begin
         ost_q <= ost_d;
         if (ost_q == OUT_ACTIVE)
            dead_cnt_q <= 8'(DEAD_TICKS);
         else if (ost_q == OUT_DEAD && dts_tick)
            dead_cnt_q <= dead_cnt_q - 8'h01;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_out
         logic main_d;
         assign main_d = (ost_q == OUT_ACTIVE) ? chan_main_wave[ch] :
                         (ch < 3 && ost_q == OUT_DEAD) ? 1'b0 : idle_lvl[2*ch];
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst)
               main_out_pin[ch] <= 1'b0;
            else
               main_out_pin[ch] <= main_d;
         end
         if (ch < 3) begin : g_comp
            logic comp_d;
            assign comp_d = (ost_q == OUT_ACTIVE) ? chan_comp_wave[ch] :
                            (ost_q == OUT_DEAD) ? 1'b0 : idle_lvl[2*ch+1];
            always_ff @(posedge sys_clk or posedge rst) begin
               if (rst)
                  comp_out_pin[ch] <= 1'b0;
               else
                  comp_out_pin[ch] <= comp_d;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_pulse_update;
      single_pulse_mode && update_event && !slave_trigger_start;
   endsequence
   sequence s_outputs_drop;
      ost_q == OUT_ACTIVE ##1 !main_output_enable && ost_q == OUT_ACTIVE;
   endsequence

   single_pulse_a: assert property (s_pulse_update |=> !counter_enable_bit)
      else $error("counter enable not cleared by single pulse update");
   trig_start_a: assert property (slave_trigger_start |=> counter_enable_bit)
      else $error("trigger start did not set counter enable");
   update_block_a: assert property (update_disable |-> !update_event)
      else $error("update event while updates disabled");
   urs_filter_a: assert property (update_irq_req |-> counter_wrap || !update_source_select)
      else $error("update request from filtered source");
   reload_direct_a: assert property (arr_wr && !buf_en |=>
      auto_reload_value == $past(arr_wdata)) else $error("direct reload missed");
   reload_held_a: assert property (buf_en && !update_event |=>
      $stable(auto_reload_value)) else $error("buffered reload changed early");
   idle_lock_a: assert property (locked |=> $stable(idle_lvl))
      else $error("idle levels changed under lock");
   trigger_output_update_a: assert property (trigger_output_src == TRIGGER_OUTPUT_UPDATE && update_event
      |=> trigger_output) else $error("trigger output missed update");
   debug_freeze_a: assert property (halt_s && freeze_s |-> !count_run)
      else $error("counter runs while frozen in debug");
   dead_time_a: assert property (s_outputs_drop |=> ##1 comp_out_pin == 3'h0
      || DEAD_TICKS == 0) else $error("comp outputs not inactive in dead-time");
   combine_in_a: assert property (combine |-> channel_in_one == ^chan_s)
      else $error("input combiner wrong");
   dma_sel_a: assert property (dma_sel |-> channel_dma_req == {4{update_event}})
      else $error("channel dma not on update");
   comm_load_a: assert property (ctrl_pre && !commutation_event && !cc_ctrl_wr
      |=> $stable(cc_ctrl_active)) else $error("preloaded controls loaded early");
endmodule : adv_timer_control_regs
`default_nettype wire

// ---- adv_timer_pkg.sv ----
`default_nettype none
package adv_timer_pkg;
   localparam logic [7:0]  CTRL_ONE_OFF   = 8'h00;
   localparam logic [7:0]  CTRL_TWO_OFF   = 8'h04;
   localparam logic [15:0] CTRL_ONE_RST   = 16'h0000;
   localparam logic [15:0] CTRL_TWO_RST   = 16'h0000;
   localparam logic [15:0] CTRL_ONE_MASK  = 16'h03ff;
   localparam logic [15:0] CTRL_TWO_MASK  = 16'h7ffd;
   localparam logic [3:0]  BE_HALF        = 4'h3;
   localparam logic [3:0]  BE_WORD        = 4'hf;
   // Counter control one fields
   localparam int CKD_LSB  = 8;
   localparam int RELOAD_BUFFER_ENABLE_BIT = 7;
   localparam int CMS_LSB  = 5;
   localparam int DIR_BIT  = 4;
   localparam int OPM_BIT  = 3;
   localparam int URS_BIT  = 2;
   localparam int UPDATE_DISABLE_BIT = 1;
   localparam int CEN_BIT  = 0;
   // Counter control two fields; idle bits 8 to 14 are main1,comp1,main2,comp2,main3,comp3,main4
   localparam int OIS_LSB  = 8;
   localparam int OIS_MSB  = 14;
   localparam int INPUT_COMBINE_SELECT_BIT = 7;
   localparam int MMS_LSB  = 4;
   localparam int CHANNEL_DMA_SELECT_BIT = 3;
   localparam int COMMUTATION_SOURCE_SELECT_BIT = 2;
   localparam int CONTROL_PRELOAD_ENABLE_BIT = 0;
   localparam logic [1:0] ALIGN_EDGE = 2'h0;
   localparam logic [1:0] ALIGN_DOWN = 2'h1;
   localparam logic [1:0] ALIGN_UP   = 2'h2;
   localparam logic [1:0] ALIGN_BOTH = 2'h3;
   localparam logic [1:0] DIV_BY1    = 2'h0;
   localparam logic [1:0] DIV_BY2    = 2'h1;
   localparam logic [1:0] LOCK_OFF   = 2'h0;
   localparam logic [2:0] TRIGGER_OUTPUT_RESET  = 3'h0;
   localparam logic [2:0] TRIGGER_OUTPUT_ENABLE = 3'h1;
   localparam logic [2:0] TRIGGER_OUTPUT_UPDATE = 3'h2;
   localparam logic [2:0] TRIGGER_OUTPUT_PULSE  = 3'h3;
   localparam int DEAD_TICKS_DEF = 4;
   typedef enum logic [2:0] {
      OUT_ACTIVE = 3'b001,
      OUT_DEAD   = 3'b010,
      OUT_IDLE   = 3'b100
   } out_state_e;
endpackage : adv_timer_pkg
`default_nettype wire

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ---- dts_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module dts_divider
   import adv_timer_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [1:0] divide_code,
   output logic            dts_tick
);
   logic [1:0] cnt_q;
   logic [1:0] limit;
   // Reserved code falls back to the slowest rate
   assign limit = (divide_code == DIV_BY1) ? 2'h0 :
                  (divide_code == DIV_BY2) ? 2'h1 : 2'h3;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q    <= 2'h0;
         dts_tick <= 1'b0;
      end else begin
         cnt_q    <= (cnt_q >= limit) ? 2'h0 : cnt_q + 2'h1;
         dts_tick <= (cnt_q >= limit);
      end
   end
endmodule : dts_divider
`default_nettype wire

// ---- adv_timer_control_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module adv_timer_control_regs_test;
   import adv_timer_pkg::*;
   logic        sys_clk, rst, reg_wr, reg_rd, debug_halt, debug_freeze_bit, trigger_input;
   logic        counter_wrap, update_generate_request, slave_update, slave_trigger_start;
   logic        gated_active, encoder_mode, hw_dir_down, master_slave_delay, main_output_enable;
   logic        commutation_generate, arr_wr, cc_ctrl_wr;
   logic [7:0]  reg_addr;
   logic [3:0]  reg_be, chan_main_wave, channel_event, compare_reference;
   logic [31:0] reg_wdata;
   logic [2:0]  chan_pin, chan_comp_wave;
   logic [1:0]  lock_level;
   logic [15:0] arr_wdata, m1, m2, v;
   logic [11:0] cc_ctrl_wdata, ccv;
   wire  [31:0] reg_rdata;
   wire         count_run, count_down, compare_flag_enable, dts_tick, update_event;
   wire         update_irq_req, counter_reinit, channel_in_one, commutation_event, trigger_output;
   wire  [3:0]  channel_dma_req, main_out_pin;
   wire  [15:0] auto_reload_value;
   wire  [11:0] cc_ctrl_active;
   wire  [2:0]  comp_out_pin;
   int          miscompares, n_tests, n;
   adv_timer_control_regs u_adv_timer_control_regs (
      .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .debug_halt(debug_halt),
      .debug_freeze_bit(debug_freeze_bit), .trigger_input(trigger_input), .chan_pin(chan_pin),
      .counter_wrap(counter_wrap), .update_generate_request(update_generate_request),
      .slave_update(slave_update), .slave_trigger_start(slave_trigger_start),
      .gated_active(gated_active), .encoder_mode(encoder_mode), .hw_dir_down(hw_dir_down),
      .master_slave_delay(master_slave_delay), .lock_level(lock_level),
      .main_output_enable(main_output_enable), .chan_main_wave(chan_main_wave),
      .chan_comp_wave(chan_comp_wave), .channel_event(channel_event),
      .compare_reference(compare_reference), .commutation_generate(commutation_generate),
      .arr_wr(arr_wr), .arr_wdata(arr_wdata), .cc_ctrl_wr(cc_ctrl_wr),
      .cc_ctrl_wdata(cc_ctrl_wdata), .count_run(count_run), .count_down(count_down),
      .compare_flag_enable(compare_flag_enable), .dts_tick(dts_tick),
      .update_event(update_event), .update_irq_req(update_irq_req),
      .counter_reinit(counter_reinit), .channel_in_one(channel_in_one),
      .channel_dma_req(channel_dma_req), .commutation_event(commutation_event),
      .auto_reload_value(auto_reload_value), .cc_ctrl_active(cc_ctrl_active),
      .main_out_pin(main_out_pin), .comp_out_pin(comp_out_pin), .trigger_output(trigger_output)
   );
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task tick;
      @(posedge sys_clk);
      #1;
   endtask : tick
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Model of both registers kept beside the bus cycle
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
      reg_addr = a; reg_wdata = {16'h0000, d}; reg_be = be; reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      if (be == BE_HALF || be == BE_WORD) begin
         if (a == CTRL_ONE_OFF)
            m1 = (d & CTRL_ONE_MASK & ~16'h0010) |
                 (((m1[6:5] != ALIGN_EDGE) || encoder_mode) ? (m1 & 16'h0010) : (d & 16'h0010));
         if (a == CTRL_TWO_OFF)
            m2 = (lock_level != LOCK_OFF) ? ((d & CTRL_TWO_MASK & 16'h00ff) | (m2 & 16'h7f00))
                                          : (d & CTRL_TWO_MASK);
      end
      tick;
   endtask : wr
   task rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr = a; reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      chk("reg_rdata", {16'h0000, e}, reg_rdata);
      tick;
   endtask : rd
   // Drives wrap, software and slave update sources as one code
   task ev(input logic [2:0] s);
      {slave_update, update_generate_request, counter_wrap} = s;
   endtask : ev
   task tally_and_finish;
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      void'($urandom(32'h383acb94));
      {reg_wr, reg_rd, debug_halt, debug_freeze_bit, trigger_input, counter_wrap} = '0;
      {update_generate_request, slave_update, slave_trigger_start, gated_active} = '0;
      {encoder_mode, hw_dir_down, master_slave_delay, commutation_generate, arr_wr} = '0;
      {cc_ctrl_wr, reg_addr, reg_be, reg_wdata, chan_pin, lock_level, arr_wdata} = '0;
      {cc_ctrl_wdata, channel_event, compare_reference} = '0;
      main_output_enable = 1'b1; chan_main_wave = 4'($urandom); chan_comp_wave = 3'($urandom);
      miscompares = 0; n_tests = 0; m1 = CTRL_ONE_RST; m2 = CTRL_TWO_RST;
      rst = 1'b1;
      repeat (20) tick;
      rst = 1'b0;
      tick;
      rd(CTRL_ONE_OFF, 16'h0000);
      rd(CTRL_TWO_OFF, 16'h0000);
      rd(8'h08, 16'h0000);
      wr(CTRL_ONE_OFF, 16'hff9e, BE_WORD);
      rd(CTRL_ONE_OFF, m1);
      wr(CTRL_ONE_OFF, 16'h0000, 4'h1);
      reg_be = 4'h1;
      rd(CTRL_ONE_OFF, m1);
      encoder_mode = 1'b1; hw_dir_down = 1'($urandom); #1;
      chk("count_down", 32'(hw_dir_down), 32'(count_down));
      encoder_mode = 1'b0;
      for (int c = 0; c < 4; c++) for (int d = 0; d < 2; d++) begin
         hw_dir_down = d[0];
         wr(CTRL_ONE_OFF, 16'(c << 5) | 16'h0010, BE_HALF);
         chk("count_down", (c == 0) ? 32'(m1[4]) : d, 32'(count_down));
         chk("compare_flag_enable", (c == 0 || c == 3) ? 1 : ((c == 1) ? d : 1 - d),
             32'(compare_flag_enable));
      end
      for (int k = 0; k < 3; k++) begin
         wr(CTRL_ONE_OFF, 16'(k << CKD_LSB), BE_WORD);
         repeat (4) tick;
         n = 0;
         repeat (16) begin tick; n += dts_tick; end
         chk("dts_tick count", 16 >> k, n);
      end
      wr(CTRL_ONE_OFF, 16'h0009, BE_WORD);
      chk("count_run", 1, 32'(count_run));
      ev(3'h1); #1;
      chk("update_event", 1, 32'(update_event));
      tick; ev(3'h0); m1[0] = 1'b0;
      rd(CTRL_ONE_OFF, m1);
      for (int u = 0; u < 3; u++) begin
         wr(CTRL_ONE_OFF, (u == 1) ? 16'h0004 : ((u == 2) ? 16'h0002 : 16'h0000), BE_WORD);
         for (int s = 1; s < 8; s = s * 2) begin
            ev(3'(s)); #1;
            chk("update_event", (u == 2) ? 0 : 1, 32'(update_event));
            chk("update_irq_req", (u == 2) ? 0 : ((u == 1) ? (s == 1) : 1),
                32'(update_irq_req));
            if (u == 2 && s != 1) chk("counter_reinit", 1, 32'(counter_reinit));
            tick; ev(3'h0); tick;
         end
      end
      wr(CTRL_ONE_OFF, 16'h0000, BE_WORD);
      for (int k = 0; k < 3; k++) begin
         if (k > 0) wr(CTRL_ONE_OFF, (k == 1) ? 16'h0080 : 16'h0082, BE_WORD);
         v = auto_reload_value; arr_wdata = 16'($urandom); arr_wr = 1'b1;
         tick;
         arr_wr = 1'b0; tick;
         chk("auto_reload_value", (k == 0) ? arr_wdata : v, auto_reload_value);
         ev(3'h1); tick; ev(3'h0); tick;
         chk("auto_reload_value", (k == 2) ? v : arr_wdata, auto_reload_value);
      end
      wr(CTRL_ONE_OFF, 16'h0000, BE_WORD);
      for (int c = 0; c < 8; c++) begin
         if (c == 1) continue;
         wr(CTRL_TWO_OFF, 16'(c << MMS_LSB), BE_WORD);
         tick;
         if (c < 3) update_generate_request = 1'b1;
         else if (c == 3) channel_event = 4'h1;
         else compare_reference = 4'(1 << (c - 4));
         tick;
         {update_generate_request, channel_event, compare_reference} = '0;
         chk("trigger_output", 1, 32'(trigger_output));
         tick;
         chk("trigger_output", 0, 32'(trigger_output));
      end
      wr(CTRL_TWO_OFF, 16'(TRIGGER_OUTPUT_ENABLE) << MMS_LSB, BE_WORD);
      gated_active = 1'b1;
      repeat (3) tick;
      chk("trigger_output", 1, 32'(trigger_output));
      chk("count_run", 1, 32'(count_run));
      gated_active = 1'b0;
      repeat (3) tick;
      chk("trigger_output", 0, 32'(trigger_output));
      channel_event = 4'($urandom) | 4'h1; #1;
      chk("channel_dma_req", 32'(channel_event), 32'(channel_dma_req));
      channel_event = 4'h0;
      wr(CTRL_TWO_OFF, 16'h0008, BE_WORD);
      update_generate_request = 1'b1; #1;
      chk("channel_dma_req", 32'hf, 32'(channel_dma_req));
      update_generate_request = 1'b0;
      chan_pin = 3'($urandom);
      for (int k = 0; k < 2; k++) begin
         wr(CTRL_TWO_OFF, (k == 0) ? 16'h0080 : 16'h0000, BE_WORD);
         repeat (3) tick;
         chk("channel_in_one", (k == 0) ? 32'(^chan_pin) : 32'(chan_pin[0]),
             32'(channel_in_one));
      end
      // Trigger pin goes through the synchroniser, so give it room before the check
      for (int k = 0; k < 4; k++) begin
         wr(CTRL_TWO_OFF, (k == 0) ? 16'h0001 : ((k == 2) ? 16'h0000 : 16'h0005), BE_WORD);
         master_slave_delay = (k == 3);
         ccv = cc_ctrl_active; cc_ctrl_wdata = 12'($urandom); cc_ctrl_wr = 1'b1;
         tick;
         cc_ctrl_wr = 1'b0; tick;
         chk("cc_ctrl_active", (k == 2) ? cc_ctrl_wdata : ccv, cc_ctrl_active);
         if (k == 0) commutation_generate = 1'b1;
         if (k[0]) trigger_input = 1'b1;
         #1;
         if (k == 0) chk("commutation_event", 1, 32'(commutation_event));
         repeat (5) tick;
         {commutation_generate, trigger_input, master_slave_delay} = '0;
         chk("cc_ctrl_active", cc_ctrl_wdata, cc_ctrl_active);
      end
      wr(CTRL_TWO_OFF, 16'($urandom) & 16'h7f00, BE_WORD);
      v = m2;
      repeat (3) tick;
      chk("main_out_pin", 32'(chan_main_wave), 32'(main_out_pin));
      chk("comp_out_pin", 32'(chan_comp_wave), 32'(comp_out_pin));
      main_output_enable = 1'b0;
      repeat (12) tick;
      chk("main_out_pin", 32'({v[14], v[12], v[10], v[8]}), 32'(main_out_pin));
      chk("comp_out_pin", 32'({v[13], v[11], v[9]}), 32'(comp_out_pin));
      lock_level = 2'($urandom % 3) + 2'h1;
      wr(CTRL_TWO_OFF, ~v, BE_HALF);
      rd(CTRL_TWO_OFF, m2);
      lock_level = LOCK_OFF;
      wr(CTRL_ONE_OFF, 16'h0001, BE_WORD);
      debug_halt = 1'b1; debug_freeze_bit = 1'b1;
      repeat (3) tick;
      chk("count_run", 0, 32'(count_run));
      debug_freeze_bit = 1'b0;
      repeat (3) tick;
      chk("count_run", 1, 32'(count_run));
      debug_halt = 1'b0;
      wr(CTRL_ONE_OFF, 16'h0000, BE_WORD);
      slave_trigger_start = 1'b1;
      tick;
      slave_trigger_start = 1'b0; m1[0] = 1'b1;
      rd(CTRL_ONE_OFF, m1);
      tally_and_finish;
   end
endmodule : adv_timer_control_regs_test
`default_nettype wire
